/* File: inc/pio_pkg.sv */
// constants, register map and state type for the pio setup completion sequence
package pio_pkg;
  // register byte offsets on the apb port
  localparam logic [7:0] OFS_TASKFILE  = 8'h00;
  localparam logic [7:0] OFS_CMD_ISSUE = 8'h04;
  localparam logic [7:0] OFS_QUEUED    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFS_CTRL      = 8'h14;
  localparam logic [7:0] OFS_CCC_COUNT = 8'h18;
  localparam logic [7:0] OFS_TARGET    = 8'h1C;
  // widths
  localparam int TGT_W  = 4;
  localparam int SLOT_W = 6;
  localparam int NSLOTS = 32;
  localparam int CNT_W  = 16;
  // task file status bit positions
  localparam int STS_ERR_BIT = 0;
  localparam int STS_DRQ_BIT = 3;
  localparam int STS_BSY_BIT = 7;
  // taskfile read word layout
  localparam int TF_ERR_LSB  = 8;
  localparam int TF_BSY_BIT  = 16;
  localparam int TF_DRQ_BIT  = 17;
  // irq status and mask layout
  localparam int IRQ_PSS_BIT = 0;
  localparam int IRQ_GLB_BIT = 1;
  localparam int IRQ_W       = 2;
  // control register layout
  localparam int CTRL_FBS_BIT = 0;
  localparam int CTRL_CCC_BIT = 1;
  localparam int CTRL_W       = 2;
  // reset values and special codes
  localparam logic [7:0]        TF_STATUS_RST = 8'h00;
  localparam logic [7:0]        TF_ERROR_RST  = 8'h00;
  localparam logic [SLOT_W-1:0] NO_SLOT       = 6'h20;
  // sequence states
  typedef enum logic [3:0] {
    st_wait, state_a, state_slot_clear, state_coalesce_count, state_port_irq_set,
    state_global_status_set, state_irq_generate, state_aggressive_power,
    state_fatal_taskfile_error, state_switching_idle, state_port_idle
  } state_t;
endpackage

/* File: hw/target_store.sv */
// per-target saved variables of the pio setup sequence, one entry per target
`timescale 1ns/1ps
module target_store #(
  parameter int TGT_W  = 4,
  parameter int SLOT_W = 6,
  parameter logic [SLOT_W-1:0] NO_SLOT = 6'h20,
  parameter int BSY_BIT = 7,
  parameter int DRQ_BIT = 3
) (
  input  wire logic              clk,         // system clock
  input  wire logic              rst,         // sync reset, high
  input  wire logic              cap_valid,   // pio setup fis received
  input  wire logic [TGT_W-1:0]  cap_tgt,     // target of that fis
  input  wire logic [7:0]        cap_ests,    // its ending status
  input  wire logic [7:0]        cap_err,     // its error field
  input  wire logic              cap_irq,     // its interrupt bit
  input  wire logic              iss_valid,   // command issued to a target
  input  wire logic [TGT_W-1:0]  iss_tgt,     // target of that command
  input  wire logic [SLOT_W-1:0] iss_slot,    // slot of that command
  input  wire logic              upd,         // update step on idx
  input  wire logic              clr_slot,    // slot retire step on idx
  input  wire logic [TGT_W-1:0]  idx,         // current target
  output logic [7:0]             ests,        // saved ending status at idx
  output logic [7:0]             err,         // saved error at idx
  output logic                   irq_flag,    // saved interrupt bit at idx
  output logic                   pending,     // transfer pending at idx
  output logic                   busy,        // busy shadow at idx
  output logic                   drq,         // data request shadow at idx
  output logic [SLOT_W-1:0]      slot         // issued slot at idx
);
  localparam int N = 1 << TGT_W;

  logic [7:0]        ests_reg [N];
  logic [7:0]        err_reg  [N];
  logic [SLOT_W-1:0] slot_reg [N];
  logic [N-1:0]      irq_reg;
  logic [N-1:0]      pend_reg;
  logic [N-1:0]      busy_reg;
  logic [N-1:0]      drq_reg;

  // every entry only moves when its own index is selected
  for (genvar i = 0; i < N; i++) begin : g_ent
    wire cap_hit = cap_valid && (cap_tgt == TGT_W'(i));
    wire upd_hit = upd && (idx == TGT_W'(i));
    wire clr_hit = clr_slot && (idx == TGT_W'(i));
    wire iss_hit = iss_valid && (iss_tgt == TGT_W'(i));
    always_ff @(posedge clk) begin
      if (rst) begin
        ests_reg[i] <= 8'h00;
        err_reg[i]  <= 8'h00;
        slot_reg[i] <= NO_SLOT;
        irq_reg[i]  <= 1'b0;
        pend_reg[i] <= 1'b0;
        busy_reg[i] <= 1'b0;
        drq_reg[i]  <= 1'b0;
      end else begin
        if (cap_hit) begin
          ests_reg[i] <= cap_ests;
          err_reg[i]  <= cap_err;
          irq_reg[i]  <= cap_irq;
        end
        // a new setup fis wins over the update clearing the pending flag
        if (cap_hit) pend_reg[i] <= 1'b1;
        else if (upd_hit) pend_reg[i] <= 1'b0;
        if (upd_hit) begin
          busy_reg[i] <= ests_reg[i][BSY_BIT];
          drq_reg[i]  <= ests_reg[i][DRQ_BIT];
        end
        if (iss_hit) slot_reg[i] <= iss_slot;
        else if (clr_hit) slot_reg[i] <= NO_SLOT;
      end
    end
  end

  // reads only ever look at the selected target
  assign ests     = ests_reg[idx];
  assign err      = err_reg[idx];
  assign irq_flag = irq_reg[idx];
  assign pending  = pend_reg[idx];
  assign busy     = busy_reg[idx];
  assign drq      = drq_reg[idx];
  assign slot     = slot_reg[idx];
endmodule

/* File: hw/pio_setup_completion_fsm.sv */
// pio setup completion sequence with apb registers and interrupt line
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
module pio_setup_completion_fsm (
  input  wire logic                        CLOCK,        // 200 mhz clock
  input  wire logic                        SYS_RST,      // sync reset, high
  input  wire logic [7:0]                  PADDR,        // apb address
  input  wire logic                        PSEL,         // apb select
  input  wire logic                        PENABLE,      // apb enable
  input  wire logic                        PWRITE,       // apb direction
  input  wire logic [31:0]                 PWDATA,       // apb write data
  output logic [31:0]                      PRDATA,       // apb read data
  output logic                             PREADY,       // apb ready
  output logic                             PSLVERR,      // apb error, unmapped
  input  wire logic                        SETUP_VALID,  // pio setup fis received
  input  wire logic [pio_pkg::TGT_W-1:0]   SETUP_TGT,    // its target
  input  wire logic [7:0]                  SETUP_ESTS,   // its ending status
  input  wire logic [7:0]                  SETUP_ERR,    // its error field
  input  wire logic                        SETUP_IRQ,    // its interrupt bit
  input  wire logic                        ISSUE_VALID,  // command issued pulse
  input  wire logic [pio_pkg::TGT_W-1:0]   ISSUE_TGT,    // its target
  input  wire logic [pio_pkg::SLOT_W-1:0]  ISSUE_SLOT,   // its slot
  input  wire logic                        UPDATE_REQ,   // transfer finished pulse
  input  wire logic [31:0]                 XFER_BYTES,   // bytes moved so far
  output logic                             BC_WR,        // byte count write pulse
  output logic [pio_pkg::SLOT_W-1:0]       BC_SLOT,      // header slot to write
  output logic [31:0]                      BC_VALUE,     // byte count to write
  output logic                             CMD_DONE,     // command retired pulse
  output logic                             FATAL_ERR,    // fatal task file exit
  output logic                             SWITCH_IDLE,  // switching idle exit
  output logic                             PORT_IDLE,    // port idle exit
  output logic                             AGGR_POWER,   // power state exit
  output logic                             BUSY_SEQ,     // sequence running
  output logic                             IRQ           // level interrupt
);
  import pio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state and registers
  state_t               state_reg, state_next;
  logic [TGT_W-1:0]     cur_tgt_reg;
  logic [TGT_W-1:0]     tgt_sel_reg;
  logic [7:0]           tf_status_reg, tf_error_reg;
  logic [NSLOTS-1:0]    cmd_issue_reg, queued_reg;
  logic [IRQ_W-1:0]     irq_stat_reg, irq_mask_reg;
  logic [CTRL_W-1:0]    ctrl_reg;
  logic [CNT_W-1:0]     ccc_count_reg;
  logic                 irq_reg, pready_reg, pslverr_reg;
  logic [31:0]          prdata_reg;
  logic                 bc_wr_reg, done_reg, fatal_reg, swi_reg, pidle_reg, aggr_reg;
  logic [SLOT_W-1:0]    bc_slot_reg;
  logic [31:0]          bc_value_reg;
  logic                 busy_seq_reg;

  wire [7:0]        st_ests, st_err;
  wire [SLOT_W-1:0] st_slot;
  wire              st_irq, st_pend, st_busy, st_drq;
  wire              in_update, in_clear;

  ////////////////////////////////////////////////////////////////////////////
  // per-target storage
  target_store #(
    .TGT_W   (TGT_W),
    .SLOT_W  (SLOT_W),
    .NO_SLOT (NO_SLOT),
    .BSY_BIT (STS_BSY_BIT),
    .DRQ_BIT (STS_DRQ_BIT)
  ) u_store (
    .clk       (CLOCK),
    .rst       (SYS_RST),
    .cap_valid (SETUP_VALID),
    .cap_tgt   (SETUP_TGT),
    .cap_ests  (SETUP_ESTS),
    .cap_err   (SETUP_ERR),
    .cap_irq   (SETUP_IRQ),
    .iss_valid (ISSUE_VALID),
    .iss_tgt   (ISSUE_TGT),
    .iss_slot  (ISSUE_SLOT),
    .upd       (in_update),
    .clr_slot  (in_clear),
    .idx       (cur_tgt_reg),
    .ests      (st_ests),
    .err       (st_err),
    .irq_flag  (st_irq),
    .pending   (st_pend),
    .busy      (st_busy),
    .drq       (st_drq),
    .slot      (st_slot)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; one wait state so read data can come from a flop
  wire acc      = PSEL && PENABLE && !pready_reg;
  wire wr_fire  = PSEL && PENABLE && PWRITE && pready_reg;
  wire hit_tf   = (PADDR == OFS_TASKFILE);
  wire hit_ci   = (PADDR == OFS_CMD_ISSUE);
  wire hit_q    = (PADDR == OFS_QUEUED);
  wire hit_is   = (PADDR == OFS_IRQ_STAT);
  wire hit_ie   = (PADDR == OFS_IRQ_MASK);
  wire hit_ctl  = (PADDR == OFS_CTRL);
  wire hit_cnt  = (PADDR == OFS_CCC_COUNT);
  wire hit_tg   = (PADDR == OFS_TARGET);
  wire mapped   = hit_tf | hit_ci | hit_q | hit_is | hit_ie | hit_ctl | hit_cnt | hit_tg;
  wire [31:0] tf_word = {14'h0000, st_drq, st_busy, tf_error_reg, tf_status_reg};
  wire [31:0] rd_mux  = hit_tf  ? tf_word :
                        hit_ci  ? cmd_issue_reg :
                        hit_q   ? queued_reg :
                        hit_is  ? {30'h0000_0000, irq_stat_reg} :
                        hit_ie  ? {30'h0000_0000, irq_mask_reg} :
                        hit_ctl ? {30'h0000_0000, ctrl_reg} :
                        hit_cnt ? {16'h0000, ccc_count_reg} :
                        hit_tg  ? {28'h0000_000, tgt_sel_reg} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // sequence decode
  assign in_update = (state_reg == state_a);
  assign in_clear  = (state_reg == state_slot_clear);
  wire slot_ok   = (st_slot < NO_SLOT);
  wire [4:0] slot5 = st_slot[4:0];
  wire ccc_go    = ctrl_reg[CTRL_CCC_BIT] && slot_ok && !queued_reg[slot5];
  wire [NSLOTS-1:0] ci_clr = (in_clear && slot_ok) ? (32'h0000_0001 << slot5) : '0;
  wire [NSLOTS-1:0] ci_set = (wr_fire && hit_ci) ? PWDATA : '0;
  wire [IRQ_W-1:0]  is_set = {state_reg == state_global_status_set,
                              state_reg == state_port_irq_set};
  wire [IRQ_W-1:0]  is_w1c = (wr_fire && hit_is) ? PWDATA[IRQ_W-1:0] : '0;

  // next state; exits last one cycle and drive the matching pulse
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_wait:
        if (UPDATE_REQ) state_next = state_a;
      state_a:
        if (st_ests[STS_ERR_BIT]) state_next = state_fatal_taskfile_error;
        else if (!st_ests[STS_BSY_BIT] && !st_ests[STS_DRQ_BIT])
          state_next = state_slot_clear;
        else if (st_irq) state_next = state_port_irq_set;
        else if (ctrl_reg[CTRL_FBS_BIT]) state_next = state_switching_idle;
        else state_next = state_port_idle;
      state_slot_clear:
        if (ccc_go) state_next = state_coalesce_count;
        else if (st_irq) state_next = state_port_irq_set;
        else state_next = state_aggressive_power;
      state_coalesce_count:
        state_next = st_irq ? state_port_irq_set : state_aggressive_power;
      state_port_irq_set:
        state_next = irq_mask_reg[IRQ_PSS_BIT] ? state_global_status_set
                                               : state_aggressive_power;
      state_global_status_set:
        state_next = irq_mask_reg[IRQ_GLB_BIT] ? state_irq_generate
                                               : state_aggressive_power;
      state_irq_generate:
        state_next = state_aggressive_power;
      default:
        state_next = st_wait;
    endcase
  end

  // state, current target and exit pulses
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_reg    <= st_wait;
      cur_tgt_reg  <= '0;
      fatal_reg    <= 1'b0;
      swi_reg      <= 1'b0;
      pidle_reg    <= 1'b0;
      aggr_reg     <= 1'b0;
      busy_seq_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      if (state_reg == st_wait && UPDATE_REQ) cur_tgt_reg <= tgt_sel_reg;
      fatal_reg    <= (state_next == state_fatal_taskfile_error);
      swi_reg      <= (state_next == state_switching_idle);
      pidle_reg    <= (state_next == state_port_idle);
      aggr_reg     <= (state_next == state_aggressive_power);
      busy_seq_reg <= (state_next != st_wait);
    end
  end

  // task file loads in the update step
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      tf_status_reg <= TF_STATUS_RST;
      tf_error_reg  <= TF_ERROR_RST;
    end else if (in_update) begin
      tf_status_reg <= st_ests;
      tf_error_reg  <= st_err;
    end
  end

  // slot retire: byte count write, done pulse, issue bit clear
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      bc_wr_reg    <= 1'b0;
      bc_slot_reg  <= NO_SLOT;
      bc_value_reg <= 32'h0000_0000;
      done_reg     <= 1'b0;
    end else begin
      bc_wr_reg    <= in_clear && slot_ok;
      done_reg     <= in_clear;
      if (in_clear) begin
        bc_slot_reg  <= st_slot;
        bc_value_reg <= XFER_BYTES;
      end
    end
  end

  // software sets issue bits, the sequence clears them; a set wins a same-cycle clear
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cmd_issue_reg <= '0;
      ccc_count_reg <= '0;
    end else begin
      cmd_issue_reg <= (cmd_issue_reg & ~ci_clr) | ci_set;
      if (state_reg == state_coalesce_count) ccc_count_reg <= ccc_count_reg + 1'b1;
    end
  end

  // sticky irq status: hardware set wins over a write-one clear
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_stat_reg <= '0;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~is_w1c) | is_set;
      irq_reg      <= (state_reg == state_irq_generate)
                      || (irq_reg && irq_stat_reg[IRQ_GLB_BIT]);
    end
  end

  // software registers and apb answer
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      queued_reg   <= '0;
      irq_mask_reg <= '0;
      ctrl_reg     <= '0;
      tgt_sel_reg  <= '0;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      prdata_reg   <= 32'h0000_0000;
    end else begin
      if (wr_fire && hit_q)   queued_reg   <= PWDATA;
      if (wr_fire && hit_ie)  irq_mask_reg <= PWDATA[IRQ_W-1:0];
      if (wr_fire && hit_ctl) ctrl_reg     <= PWDATA[CTRL_W-1:0];
      if (wr_fire && hit_tg)  tgt_sel_reg  <= PWDATA[TGT_W-1:0];
      pready_reg  <= acc;
      pslverr_reg <= acc && !mapped;
      prdata_reg  <= (acc && !PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  assign PRDATA      = prdata_reg;
  assign PREADY      = pready_reg;
  assign PSLVERR     = pslverr_reg;
  assign BC_WR       = bc_wr_reg;
  assign BC_SLOT     = bc_slot_reg;
  assign BC_VALUE    = bc_value_reg;
  assign CMD_DONE    = done_reg;
  assign FATAL_ERR   = fatal_reg;
  assign SWITCH_IDLE = swi_reg;
  assign PORT_IDLE   = pidle_reg;
  assign AGGR_POWER  = aggr_reg;
  assign BUSY_SEQ    = busy_seq_reg;
  assign IRQ         = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence s_gen_then_power;
    // the exit pulse comes with the power state itself, then the sequence goes idle
    (state_reg == state_aggressive_power && AGGR_POWER && IRQ) ##1 !BUSY_SEQ;
  endsequence

  property p_status_load;
    in_update |=> tf_status_reg == $past(st_ests);
  endproperty
  a_status_load: assert property (p_status_load) else $error("status not loaded");

  property p_error_load;
    in_update |=> tf_error_reg == $past(st_err);
  endproperty
  a_error_load: assert property (p_error_load) else $error("error not loaded");

  property p_shadow;
    in_update |=> (st_busy == $past(st_ests[STS_BSY_BIT])) && !st_pend;
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow or pending wrong");

  property p_fatal;
    in_update && st_ests[STS_ERR_BIT] |=> FATAL_ERR;
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal exit missed");

  property p_retire;
    in_clear && slot_ok |=> !cmd_issue_reg[$past(slot5)] && st_slot == NO_SLOT
                            && BC_WR && CMD_DONE;
  endproperty
  a_retire: assert property (p_retire) else $error("slot not retired");

  property p_count;
    state_reg == state_coalesce_count |=> ccc_count_reg == $past(ccc_count_reg) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("coalesce count wrong");

  property p_port_status;
    state_reg == state_port_irq_set |=> irq_stat_reg[IRQ_PSS_BIT];
  endproperty
  a_port_status: assert property (p_port_status) else $error("port status not set");

  property p_global;
    state_reg == state_global_status_set && !irq_mask_reg[IRQ_GLB_BIT]
      |=> state_reg == state_aggressive_power;
  endproperty
  a_global: assert property (p_global) else $error("global enable ignored");

  property p_generate;
    state_reg == state_irq_generate |=> s_gen_then_power;
  endproperty
  a_generate: assert property (p_generate) else $error("interrupt not raised");

  property p_hold;
    IRQ && irq_stat_reg[IRQ_GLB_BIT] |=> IRQ;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped early");
endmodule

/* File: sim/sata_device_model.sv */
// far-side model: a serial ata device announcing pio setups and issued commands
`timescale 1ns/1ps
module sata_device_model #(
  parameter logic [31:0] XFER_AMOUNT = 32'h0000_0200
) (
  input  wire logic                       CLOCK,        // system clock
  output logic                            SETUP_VALID,  // pio setup fis pulse
  output logic [pio_pkg::TGT_W-1:0]       SETUP_TGT,    // its target
  output logic [7:0]                      SETUP_ESTS,   // its ending status
  output logic [7:0]                      SETUP_ERR,    // its error field
  output logic                            SETUP_IRQ,    // its interrupt bit
  output logic                            ISSUE_VALID,  // command issued pulse
  output logic [pio_pkg::TGT_W-1:0]       ISSUE_TGT,    // its target
  output logic [pio_pkg::SLOT_W-1:0]      ISSUE_SLOT,   // its slot
  output logic [31:0]                     XFER_BYTES    // bytes moved
);
  import pio_pkg::*;
  initial begin
    {SETUP_VALID, SETUP_TGT, SETUP_ESTS, SETUP_ERR, SETUP_IRQ} = '0;
    {ISSUE_VALID, ISSUE_TGT, ISSUE_SLOT} = '0;
    XFER_BYTES = XFER_AMOUNT;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // fields are inverted once the pulse ends, so a design that reads late sees junk
  task automatic send_setup(input logic [TGT_W-1:0] t, input logic [7:0] s, input logic [7:0] e,
                            input logic i);
    @(posedge CLOCK);
    SETUP_VALID <= 1'b1;
    {SETUP_TGT, SETUP_ESTS, SETUP_ERR, SETUP_IRQ} <= {t, s, e, i};
    @(posedge CLOCK);
    SETUP_VALID <= 1'b0;
    {SETUP_TGT, SETUP_ESTS, SETUP_ERR, SETUP_IRQ} <= ~{t, s, e, i};
  endtask
  // command issue announcement, same release habit
  task automatic send_issue(input logic [TGT_W-1:0] t, input logic [SLOT_W-1:0] sl);
    @(posedge CLOCK);
    ISSUE_VALID <= 1'b1;
    {ISSUE_TGT, ISSUE_SLOT} <= {t, sl};
    @(posedge CLOCK);
    ISSUE_VALID <= 1'b0;
    {ISSUE_TGT, ISSUE_SLOT} <= ~{t, sl};
  endtask
endmodule

/* File: sim/tb_pio_setup_completion_fsm.sv */
// self-checking bench for the pio setup completion sequence
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb_pio_setup_completion_fsm;
  import pio_pkg::*;
  typedef struct packed {
    logic [7:0] sts; logic irq; logic [1:0] ctrl; logic [1:0] mask; logic [3:0] ext;
    logic [1:0] ist;
  } case_t;
  // branch table: status, irq bit, ctrl, mask, expected exit, expected irq status
  localparam case_t CASES [0:4] = '{
    '{8'h01, 1'b0, 2'h0, 2'h3, 4'b1000, 2'h0}, '{8'h80, 1'b0, 2'h1, 2'h3, 4'b0100, 2'h0},
    '{8'h08, 1'b0, 2'h0, 2'h3, 4'b0010, 2'h0}, '{8'h88, 1'b1, 2'h0, 2'h0, 4'b0001, 2'h1},
    '{8'h00, 1'b1, 2'h0, 2'h1, 4'b0001, 2'h3}};
  logic CLOCK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, UPDATE_REQ = 0;
  logic [7:0]  PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, BC_VALUE, XFER_BYTES, rdata;
  logic PREADY, PSLVERR, BC_WR, CMD_DONE, FATAL_ERR, SWITCH_IDLE, PORT_IDLE, AGGR_POWER;
  logic BUSY_SEQ, IRQ, SETUP_VALID, SETUP_IRQ, ISSUE_VALID, rerr;
  logic [TGT_W-1:0]  SETUP_TGT, ISSUE_TGT;
  logic [7:0]        SETUP_ESTS, SETUP_ERR;
  logic [SLOT_W-1:0] ISSUE_SLOT, BC_SLOT;
  logic [3:0] exitv = '0;
  int num_errors = 0, num_checks = 0, exit_n = 0, ex_base = 0, bc_n = 0, done_n = 0;
  pio_setup_completion_fsm uut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PADDR(PADDR), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SETUP_VALID(SETUP_VALID), .SETUP_TGT(SETUP_TGT),
    .SETUP_ESTS(SETUP_ESTS), .SETUP_ERR(SETUP_ERR), .SETUP_IRQ(SETUP_IRQ),
    .ISSUE_VALID(ISSUE_VALID), .ISSUE_TGT(ISSUE_TGT), .ISSUE_SLOT(ISSUE_SLOT),
    .UPDATE_REQ(UPDATE_REQ), .XFER_BYTES(XFER_BYTES), .BC_WR(BC_WR), .BC_SLOT(BC_SLOT),
    .BC_VALUE(BC_VALUE), .CMD_DONE(CMD_DONE), .FATAL_ERR(FATAL_ERR),
    .SWITCH_IDLE(SWITCH_IDLE), .PORT_IDLE(PORT_IDLE), .AGGR_POWER(AGGR_POWER),
    .BUSY_SEQ(BUSY_SEQ), .IRQ(IRQ));
  sata_device_model dev (.CLOCK(CLOCK), .SETUP_VALID(SETUP_VALID), .SETUP_TGT(SETUP_TGT),
    .SETUP_ESTS(SETUP_ESTS), .SETUP_ERR(SETUP_ERR), .SETUP_IRQ(SETUP_IRQ),
    .ISSUE_VALID(ISSUE_VALID), .ISSUE_TGT(ISSUE_TGT), .ISSUE_SLOT(ISSUE_SLOT),
    .XFER_BYTES(XFER_BYTES));
  ////////////////////////////////////////////////////////////////////////////////
  // 200 mhz clock
  initial begin
    forever #2.5 CLOCK = ~CLOCK;
  end
  // tally exit pulses and retire pulses
  always @(posedge CLOCK) begin
    if ((FATAL_ERR | SWITCH_IDLE | PORT_IDLE | AGGR_POWER) === 1'b1) begin
      exitv <= {FATAL_ERR, SWITCH_IDLE, PORT_IDLE, AGGR_POWER};
      exit_n <= exit_n + 1;
    end
    if (BC_WR === 1'b1) bc_n <= bc_n + 1;
    if (CMD_DONE === 1'b1) done_n <= done_n + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // apb master: setup, access, hold until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask
  // start a sequence; the second cycle of the request lands while busy and is ignored
  task automatic run(input logic [TGT_W-1:0] t);
    apb(1, OFS_TARGET, {28'h0, t});
    ex_base = exit_n;
    @(posedge CLOCK);
    UPDATE_REQ <= 1'b1;
    repeat (2) @(posedge CLOCK);
    UPDATE_REQ <= 1'b0;
    while (BUSY_SEQ !== 1'b0) begin
      @(posedge CLOCK);
    end
    repeat (2) @(posedge CLOCK);
    `CHK("exit count", 1, exit_n - ex_base)
  endtask
  task automatic results();
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog well past the expected few hundred cycles
  initial begin
    #100000;
    num_errors++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    apb(0, OFS_TASKFILE, 0);
    `CHK("tf reset", 32'h0, rdata)
    apb(0, 8'h20, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
    // full chain: clear, coalesce, port irq, global, generate
    apb(1, OFS_CTRL, 32'h2);
    apb(1, OFS_IRQ_MASK, 32'h3);
    apb(1, OFS_QUEUED, 32'h0);
    dev.send_issue(4'h3, 6'h05);
    apb(1, OFS_CMD_ISSUE, 32'h20);
    dev.send_setup(4'h3, 8'h40, 8'h5A, 1'b1);
    run(4'h3);
    `CHK("exit", 4'b0001, exitv)
    apb(0, OFS_TASKFILE, 0);
    `CHK("tf", 32'h0000_5A40, rdata)
    apb(0, OFS_CMD_ISSUE, 0);
    `CHK("issue", 32'h0, rdata)
    `CHK("bc slot", 6'h05, BC_SLOT)
    `CHK("bc value", 32'h0000_0200, BC_VALUE)
    `CHK("bc writes", 1, bc_n)
    `CHK("done", 1, done_n)
    apb(0, OFS_CCC_COUNT, 0);
    `CHK("ccc", 32'h1, rdata)
    apb(0, OFS_IRQ_STAT, 0);
    `CHK("irq stat", 32'h3, rdata)
    repeat (10) @(posedge CLOCK);
    `CHK("irq held", 1'b1, IRQ)
    apb(1, OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge CLOCK);
    `CHK("irq drop", 1'b0, IRQ)
    apb(1, OFS_IRQ_STAT, 32'h1);
    // branch table on other targets
    for (int i = 0; i < 5; i++) begin
      apb(1, OFS_CTRL, {30'h0, CASES[i].ctrl});
      apb(1, OFS_IRQ_MASK, {30'h0, CASES[i].mask});
      dev.send_setup(4'(i + 8), CASES[i].sts, 8'hE0 + 8'(i), CASES[i].irq);
      run(4'(i + 8));
      `CHK("exit", CASES[i].ext, exitv)
      apb(0, OFS_TASKFILE, 0);
      `CHK("tf", {14'h0,CASES[i].sts[3],CASES[i].sts[7],4'hE,4'(i),CASES[i].sts}, rdata)
      apb(0, OFS_IRQ_STAT, 0);
      `CHK("irq stat", {30'h0, CASES[i].ist}, rdata)
      `CHK("irq", 1'b0, IRQ)
      apb(1, OFS_IRQ_STAT, 32'h3);
    end
    apb(0, OFS_CCC_COUNT, 0);
    `CHK("ccc", 32'h1, rdata)
    results();
  end
endmodule
